// ===== src/acg_pkg.sv
/*
 * Shared definitions of the audio clock generator: register offsets,
 * field layouts, reset values, legal ranges and the packed state carriers.
 * Assumes a 32-bit register port with byte addresses that are word aligned.
 */
package acg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register port
	localparam int ACG_AW = 8;
	localparam int ACG_DW = 32;
	localparam logic [7:0] ACG_OFS_CTRL = 8'h00;
	localparam logic [7:0] ACG_OFS_DIVQ = 8'h04;
	localparam logic [7:0] ACG_OFS_PLLPR = 8'h08;
	localparam logic [7:0] ACG_OFS_PLLK = 8'h0c;
	localparam logic [7:0] ACG_OFS_OUTDIV = 8'h10;
	localparam logic [7:0] ACG_OFS_STATUS = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int ACG_POS_PLL_EN = 0;
	localparam int ACG_POS_MUX_SEL = 1;
	localparam int ACG_POS_CONV_PLL = 2;
	localparam int ACG_POS_PLL_SRC = 4;
	localparam int ACG_POS_DIV_SRC = 6;
	localparam int ACG_POS_Q = 0;
	localparam int ACG_POS_P = 0;
	localparam int ACG_POS_R = 8;
	localparam int ACG_POS_J = 0;
	localparam int ACG_POS_D = 16;
	localparam int ACG_POS_M = 0;
	localparam int ACG_POS_N = 8;
	localparam int ACG_POS_FS_TOTAL = 0;
	localparam int ACG_POS_AUX_LVL = 16;
	localparam int ACG_POS_AUX_RUN = 17;
	localparam int ACG_POS_SRC_PLL = 18;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [1:0] ACG_RST_DIV_SRC = 2'h0;
	localparam logic [1:0] ACG_RST_PLL_SRC = 2'h0;
	localparam logic [4:0] ACG_RST_Q = 5'h02;
	localparam logic [3:0] ACG_RST_P = 4'h1;
	localparam logic [4:0] ACG_RST_R = 5'h01;
	localparam logic [5:0] ACG_RST_J = 6'h04;
	localparam logic [13:0] ACG_RST_D = 14'h0000;
	localparam logic [3:0] ACG_RST_M = 4'h1;
	localparam logic [4:0] ACG_RST_N = 5'h02;

	////////////////////////////////////////////////////////////////////////
	// Legal ranges and scale factors
	localparam logic [4:0] ACG_QN_MIN = 5'h02;
	localparam logic [4:0] ACG_QN_MAX = 5'h11;
	localparam logic [3:0] ACG_P_MAX = 4'h8;
	localparam logic [4:0] ACG_R_MAX = 5'h10;
	localparam logic [5:0] ACG_J_MAX = 6'h3f;
	localparam logic [13:0] ACG_D_MAX = 14'h270f;
	localparam int ACG_RW = 26;
	localparam logic [25:0] ACG_FRAC_SCALE = 26'h0002710;
	localparam logic [25:0] ACG_PLL_DIV = 26'h0000010;
	localparam logic [25:0] ACG_AUX_INC = 26'h0000002;
	localparam logic [7:0] ACG_FS_LAST = 8'hff;

	////////////////////////////////////////////////////////////////////////
	// Source selection codes
	localparam logic [1:0] ACG_SRC_MCLK = 2'h0;
	localparam logic [1:0] ACG_SRC_BCLK = 2'h1;
	localparam logic [1:0] ACG_SRC_AUX = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// State carriers
	typedef struct packed {
		logic prev;
		logic edge_seen;
	} acg_edge_s;

	typedef struct packed {
		logic [26:0] acc;
		logic tick;
	} acg_rate_s;

	typedef struct packed {
		logic [1:0] div_src;
		logic [1:0] pll_src;
		logic pll_en;
		logic mux_sel;
		logic conv_pll;
		logic [4:0] q;
		logic [3:0] p;
		logic [4:0] r;
		logic [5:0] j;
		logic [13:0] d;
		logic [3:0] m;
		logic [4:0] n;
		logic [7:0] fs_cnt;
		logic fs_tick;
		logic amclk_tick;
		logic aux_lvl;
		logic aux_oe;
		logic [15:0] fs_total;
		logic [31:0] rdata;
	} acg_state_s;

endpackage : acg_pkg

// ===== src/acg_edge.sv
/*
 * Source selector and edge detector: picks one of three clock inputs and
 * gives a one-cycle pulse for each of its edges, rising and falling.
 * Assumes the inputs are synchronous to i_mclk and change at most once a cycle.
 */
`timescale 1ns/1ps

module acg_edge
	import acg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [2:0] i_src,
	input wire logic [1:0] i_sel,
	output logic o_edge
);

	acg_edge_s st_ff;
	acg_edge_s nxt_st;
	logic lvl;

	always_comb
	begin
		lvl = (i_sel == 2'h3) ? 1'b0 : i_src[i_sel];
		nxt_st = st_ff;
		nxt_st.prev = lvl;
		nxt_st.edge_seen = lvl ^ st_ff.prev;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign o_edge = st_ff.edge_seen;

endmodule : acg_edge

// ===== src/acg_rate.sv
/*
 * Fractional rate generator: adds an increment on each input event and
 * emits a tick each time the sum reaches the threshold, keeping the remainder.
 * Assumes the average tick rate stays below one per clock cycle.
 */
`timescale 1ns/1ps

module acg_rate
	import acg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic i_en,
	input wire logic [25:0] i_inc,
	input wire logic [25:0] i_thr,
	output logic o_tick
);

	acg_rate_s st_ff;
	acg_rate_s nxt_st;
	logic [26:0] sum;

	always_comb
	begin
		sum = st_ff.acc + (i_en ? {1'b0, i_inc} : 27'h0000000);
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!i_run || i_thr == 26'h0000000)
		begin
			nxt_st.acc = '0;
		end
		else if (sum >= {1'b0, i_thr})
		begin
			nxt_st.tick = 1'b1;
			nxt_st.acc = sum - {1'b0, i_thr};
		end
		else
		begin
			nxt_st.acc = sum;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign o_tick = st_ff.tick;

endmodule : acg_rate

// ===== src/acg_top.sv
/*
 * Audio clock generator: divider and fractional PLL paths that produce the
 * internal audio master clock and reference sample rate as tick pulses, and
 * a separately divided clock on the auxiliary output pin.
 * Assumes clock inputs synchronous to i_mclk, sampled once per cycle, and a
 * register master that follows the plain strobe protocol.
 */
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Operation
// - Two-bit field picks divider input: master clock, bit clock or aux input.
// - Without PLL, sample rate is divider input over 128 times Q, Q 2..17.
// - Half-integer ratio mode accepts master clock up to 50 MHz; the code has no such mode, Q is integer only.
// - With PLL, sample rate is input times K times R over 2048 P.
// - Multiplier is integer 1..63 plus four decimal fraction digits 0..9999.
// - Two-bit field picks PLL reference: master clock or bit clock.
// - While PLL clocks converters and mux is zero, aux output is PLL output over M and N.
// - PLL may drive only the aux output without clocking the converters.
// - PLL on and mux zero: aux clock is input times 2KR over MNP.
// - Mux one: output divider takes divider input whatever the PLL state.
// - Mux one: aux clock is twice divider input over M times N.
// - M accepts only 1,2,4,8; N accepts only 2..17.
// - Internal master clock runs at 256 times the reference sample rate.
module acg_top
	import acg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_mclk_in,
	input wire logic i_bclk,
	input wire logic i_aux_clock_input_pin,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_amclk_tick,
	output logic o_fsref_tick,
	output logic o_aux_clock_output_pin,
	output logic o_aux_clock_output_pin_oe
);

	////////////////////////////////////////////////////////////////////////
	// Legality and scaling helpers

	function automatic logic legal_qn(input logic [4:0] v);
		legal_qn = (v >= ACG_QN_MIN) && (v <= ACG_QN_MAX);
	endfunction : legal_qn

	function automatic logic legal_m(input logic [3:0] v);
		legal_m = (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
	endfunction : legal_m

	function automatic logic legal_range(input logic [13:0] v, input logic [13:0] hi);
		legal_range = (v >= 14'h0001) && (v <= hi);
	endfunction : legal_range

	function automatic logic [25:0] k_scaled(input logic [5:0] j, input logic [13:0] d);
		k_scaled = 26'(26'(j) * ACG_FRAC_SCALE + 26'(d));
	endfunction : k_scaled

	////////////////////////////////////////////////////////////////////////
	// State

	acg_state_s st_ff;
	acg_state_s nxt_st;

	logic div_edge;
	logic pll_edge;
	logic div_tick;
	logic pll_tick;
	logic aux_tick;
	logic pll_for_conv;
	logic aux_run;
	logic aux_en;
	logic [25:0] k_val;
	logic [25:0] div_thr;
	logic [25:0] pll_inc;
	logic [25:0] pll_thr;
	logic [25:0] aux_inc;
	logic [25:0] aux_thr;
	logic [25:0] mn_prod;

	////////////////////////////////////////////////////////////////////////
	// Clock source selection

	acg_edge u_div_edge (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_src({i_aux_clock_input_pin, i_bclk, i_mclk_in}),
		.i_sel(st_ff.div_src),
		.o_edge(div_edge)
	);

	acg_edge u_pll_edge (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_src({1'b0, i_bclk, i_mclk_in}),
		.i_sel(st_ff.pll_src),
		.o_edge(pll_edge)
	);

	////////////////////////////////////////////////////////////////////////
	// Rate arithmetic; each input edge counts, so events come at twice the
	// input frequency and the factor 2 of the output formulas falls out.

	always_comb
	begin
		k_val = k_scaled(st_ff.j, st_ff.d);
		div_thr = 26'(st_ff.q);
		pll_inc = 26'(k_val * 26'(st_ff.r));
		pll_thr = 26'(ACG_PLL_DIV * 26'(st_ff.p) * ACG_FRAC_SCALE);
		mn_prod = 26'(26'(st_ff.m) * 26'(st_ff.n));
		pll_for_conv = st_ff.pll_en && st_ff.conv_pll;
		if (st_ff.mux_sel)
		begin
			aux_run = 1'b1;
			aux_en = div_edge;
			aux_inc = ACG_AUX_INC;
			aux_thr = mn_prod;
		end
		else
		begin
			aux_run = st_ff.pll_en;
			aux_en = pll_edge;
			aux_inc = 26'(ACG_AUX_INC * pll_inc);
			aux_thr = 26'(mn_prod * 26'(st_ff.p) * ACG_FRAC_SCALE);
		end
	end

	// Any register write restarts the accumulators, so a threshold that shrinks
	// cannot leave a backlog that comes out as a long burst of ticks
	acg_rate u_div_rate (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(!pll_for_conv && !i_wr),
		.i_en(div_edge),
		.i_inc(26'h0000001),
		.i_thr(div_thr),
		.o_tick(div_tick)
	);

	acg_rate u_pll_rate (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(pll_for_conv && !i_wr),
		.i_en(pll_edge),
		.i_inc(pll_inc),
		.i_thr(pll_thr),
		.o_tick(pll_tick)
	);

	acg_rate u_aux_rate (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(aux_run && !i_wr),
		.i_en(aux_en),
		.i_inc(aux_inc),
		.i_thr(aux_thr),
		.o_tick(aux_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state: registers, sample rate counter, aux pin

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rdata = 32'h00000000;

		if (i_wr)
		begin
			unique case (i_addr)
				ACG_OFS_CTRL:
				begin
					nxt_st.pll_en = i_wdata[ACG_POS_PLL_EN];
					nxt_st.mux_sel = i_wdata[ACG_POS_MUX_SEL];
					nxt_st.conv_pll = i_wdata[ACG_POS_CONV_PLL];
					nxt_st.pll_src = i_wdata[ACG_POS_PLL_SRC +: 2];
					nxt_st.div_src = i_wdata[ACG_POS_DIV_SRC +: 2];
				end
				ACG_OFS_DIVQ:
				begin
					if (legal_qn(i_wdata[ACG_POS_Q +: 5]))
						nxt_st.q = i_wdata[ACG_POS_Q +: 5];
				end
				ACG_OFS_PLLPR:
				begin
					if (legal_range(14'(i_wdata[ACG_POS_P +: 4]), 14'(ACG_P_MAX)))
						nxt_st.p = i_wdata[ACG_POS_P +: 4];
					if (legal_range(14'(i_wdata[ACG_POS_R +: 5]), 14'(ACG_R_MAX)))
						nxt_st.r = i_wdata[ACG_POS_R +: 5];
				end
				ACG_OFS_PLLK:
				begin
					if (legal_range(14'(i_wdata[ACG_POS_J +: 6]), 14'(ACG_J_MAX)))
						nxt_st.j = i_wdata[ACG_POS_J +: 6];
					if (i_wdata[ACG_POS_D +: 14] <= ACG_D_MAX)
						nxt_st.d = i_wdata[ACG_POS_D +: 14];
				end
				ACG_OFS_OUTDIV:
				begin
					if (legal_m(i_wdata[ACG_POS_M +: 4]))
						nxt_st.m = i_wdata[ACG_POS_M +: 4];
					if (legal_qn(i_wdata[ACG_POS_N +: 5]))
						nxt_st.n = i_wdata[ACG_POS_N +: 5];
				end
				default:
				begin
				end
			endcase
		end

		if (i_rd)
		begin
			unique case (i_addr)
				ACG_OFS_CTRL:
				begin
					nxt_st.rdata[ACG_POS_PLL_EN] = st_ff.pll_en;
					nxt_st.rdata[ACG_POS_MUX_SEL] = st_ff.mux_sel;
					nxt_st.rdata[ACG_POS_CONV_PLL] = st_ff.conv_pll;
					nxt_st.rdata[ACG_POS_PLL_SRC +: 2] = st_ff.pll_src;
					nxt_st.rdata[ACG_POS_DIV_SRC +: 2] = st_ff.div_src;
				end
				ACG_OFS_DIVQ:
					nxt_st.rdata[ACG_POS_Q +: 5] = st_ff.q;
				ACG_OFS_PLLPR:
				begin
					nxt_st.rdata[ACG_POS_P +: 4] = st_ff.p;
					nxt_st.rdata[ACG_POS_R +: 5] = st_ff.r;
				end
				ACG_OFS_PLLK:
				begin
					nxt_st.rdata[ACG_POS_J +: 6] = st_ff.j;
					nxt_st.rdata[ACG_POS_D +: 14] = st_ff.d;
				end
				ACG_OFS_OUTDIV:
				begin
					nxt_st.rdata[ACG_POS_M +: 4] = st_ff.m;
					nxt_st.rdata[ACG_POS_N +: 5] = st_ff.n;
				end
				ACG_OFS_STATUS:
				begin
					nxt_st.rdata[ACG_POS_FS_TOTAL +: 16] = st_ff.fs_total;
					nxt_st.rdata[ACG_POS_AUX_LVL] = st_ff.aux_lvl;
					nxt_st.rdata[ACG_POS_AUX_RUN] = st_ff.aux_oe;
					nxt_st.rdata[ACG_POS_SRC_PLL] = pll_for_conv;
				end
				default:
				begin
				end
			endcase
		end

		// Master clock tick from whichever path clocks the converters
		nxt_st.amclk_tick = pll_for_conv ? pll_tick : div_tick;
		nxt_st.fs_tick = 1'b0;
		if (nxt_st.amclk_tick)
		begin
			if (st_ff.fs_cnt == ACG_FS_LAST)
			begin
				nxt_st.fs_cnt = 8'h00;
				nxt_st.fs_tick = 1'b1;
				nxt_st.fs_total = st_ff.fs_total + 16'h0001;
			end
			else
			begin
				nxt_st.fs_cnt = st_ff.fs_cnt + 8'h01;
			end
		end

		// Aux pin toggles on each half-period tick and idles low when stopped
		nxt_st.aux_oe = aux_run;
		if (!aux_run)
			nxt_st.aux_lvl = 1'b0;
		else if (aux_tick)
			nxt_st.aux_lvl = !st_ff.aux_lvl;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_ff <= '0;
			st_ff.div_src <= ACG_RST_DIV_SRC;
			st_ff.pll_src <= ACG_RST_PLL_SRC;
			st_ff.q <= ACG_RST_Q;
			st_ff.p <= ACG_RST_P;
			st_ff.r <= ACG_RST_R;
			st_ff.j <= ACG_RST_J;
			st_ff.d <= ACG_RST_D;
			st_ff.m <= ACG_RST_M;
			st_ff.n <= ACG_RST_N;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata = st_ff.rdata;
	assign o_amclk_tick = st_ff.amclk_tick;
	assign o_fsref_tick = st_ff.fs_tick;
	assign o_aux_clock_output_pin = st_ff.aux_lvl;
	assign o_aux_clock_output_pin_oe = st_ff.aux_oe;

endmodule : acg_top

// ===== testbench/acg_chk.sv
/*
 * Port checker of the audio clock generator: register answers, tick relations
 * and aux pin rules. Sees only the ports of acg_top; one clock domain.
 */
`timescale 1ns/1ps

module acg_chk
	import acg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_mclk_in,
	input wire logic i_bclk,
	input wire logic i_aux_clock_input_pin,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_amclk_tick,
	input wire logic o_fsref_tick,
	input wire logic o_aux_clock_output_pin,
	input wire logic o_aux_clock_output_pin_oe
);
	logic [1:0] ctl_ff;
	logic [8:0] amc_cnt_ff;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////////////
	// Shadow of PLL enable and mux bits; amclk ticks since the last fsref
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctl_ff <= 2'h0;
			amc_cnt_ff <= 9'h000;
		end
		else
		begin
			if (i_wr && i_addr == ACG_OFS_CTRL)
				ctl_ff <= i_wdata[1:0];
			if (o_fsref_tick)
				amc_cnt_ff <= 9'h000;
			else if (o_amclk_tick)
				amc_cnt_ff <= amc_cnt_ff + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_rd_answer_only: assert property (
		o_rdata != 32'h0 |-> $past(i_rd)) else $error("read data without a read");
	a_unmapped_zero: assert property (
		i_rd && i_addr > ACG_OFS_STATUS |=> o_rdata == 32'h0) else $error("unmapped read not 0");
	a_q_accept: assert property (
		i_wr && i_addr == ACG_OFS_DIVQ && i_wdata[4:0] >= ACG_QN_MIN && i_wdata[4:0] <= ACG_QN_MAX
		##1 i_rd && i_addr == ACG_OFS_DIVQ |=> o_rdata[4:0] == $past(i_wdata[4:0], 2))
		else $error("legal divider value lost");
	a_q_refuse: assert property (
		i_wr && i_addr == ACG_OFS_DIVQ && (i_wdata[4:0] < ACG_QN_MIN || i_wdata[4:0] > ACG_QN_MAX)
		##1 i_rd && i_addr == ACG_OFS_DIVQ |=> o_rdata[4:0] != $past(i_wdata[4:0], 2))
		else $error("illegal divider value taken");
	a_m_refuse: assert property (
		i_wr && i_addr == ACG_OFS_OUTDIV && !(i_wdata[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8})
		##1 i_rd && i_addr == ACG_OFS_OUTDIV |=> o_rdata[3:0] != $past(i_wdata[3:0], 2))
		else $error("illegal first output divider taken");
	a_n_accept: assert property (
		i_wr && i_addr == ACG_OFS_OUTDIV && i_wdata[12:8] >= ACG_QN_MIN && i_wdata[12:8] <= ACG_QN_MAX
		##1 i_rd && i_addr == ACG_OFS_OUTDIV |=> o_rdata[12:8] == $past(i_wdata[12:8], 2))
		else $error("legal second output divider lost");
	a_p_refuse: assert property (
		i_wr && i_addr == ACG_OFS_PLLPR && (i_wdata[3:0] == 4'h0 || i_wdata[3:0] > ACG_P_MAX)
		##1 i_rd && i_addr == ACG_OFS_PLLPR |=> o_rdata[3:0] != $past(i_wdata[3:0], 2))
		else $error("illegal pre-divider taken");
	a_d_refuse: assert property (
		i_wr && i_addr == ACG_OFS_PLLK && i_wdata[29:16] > ACG_D_MAX
		##1 i_rd && i_addr == ACG_OFS_PLLK |=> o_rdata[29:16] != $past(i_wdata[29:16], 2))
		else $error("illegal fraction taken");
	a_fs_every_256: assert property (
		o_fsref_tick |-> o_amclk_tick && amc_cnt_ff == 9'h0ff) else $error("fsref not every 256");
	a_aux_low_stopped: assert property (
		!o_aux_clock_output_pin_oe |-> !o_aux_clock_output_pin) else $error("aux pin high while off");
	a_aux_off_mux0: assert property (
		(ctl_ff == 2'h0) [*4] |-> !o_aux_clock_output_pin_oe) else $error("aux runs with no source");

	c_fsref: cover property (o_fsref_tick);
	c_aux_toggle: cover property (o_aux_clock_output_pin_oe && $changed(o_aux_clock_output_pin));
	c_unmapped: cover property (i_rd && i_addr > ACG_OFS_STATUS);

endmodule : acg_chk

bind acg_top acg_chk u_acg_chk (.i_mclk, .i_rst_n, .i_mclk_in, .i_bclk, .i_aux_clock_input_pin,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_amclk_tick, .o_fsref_tick,
	.o_aux_clock_output_pin, .o_aux_clock_output_pin_oe);

// ===== testbench/acg_src_model.sv
/*
 * External audio clock sources: master clock, bit clock and aux input as slow
 * free-running stand-ins, each toggling every HALF_x system clock cycles.
 */
`timescale 1ns/1ps

module acg_src_model #(
	parameter int HALF_M = 2,
	parameter int HALF_B = 3,
	parameter int HALF_A = 5
)
(
	input wire logic i_mclk,
	output logic o_mclk_in,
	output logic o_bclk,
	output logic o_aux
);
	localparam int HALF [3] = '{HALF_M, HALF_B, HALF_A};
	int cnt_ff [3] = '{0, 0, 0};
	logic [2:0] lvl_ff = 3'h0;

	// Sources run all the time so a converter always sees a clock
	always_ff @(posedge i_mclk)
	begin
		for (int k = 0; k < 3; k++)
		begin
			if (cnt_ff[k] == HALF[k] - 1)
			begin
				cnt_ff[k] <= 0;
				lvl_ff[k] <= ~lvl_ff[k];
			end
			else
				cnt_ff[k] <= cnt_ff[k] + 1;
		end
	end

	assign o_mclk_in = lvl_ff[0];
	assign o_bclk = lvl_ff[1];
	assign o_aux = lvl_ff[2];

endmodule : acg_src_model

// ===== testbench/testbench.sv
/*
 * Self-checking bench of the audio clock generator: reset values, field
 * refusal, divider, PLL and aux rates. Assumes acg_src_model as clock source.
 */
`timescale 1ns/1ps

module testbench
	import acg_pkg::*;
;
	localparam logic [7:0] RST_A [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
	localparam logic [31:0] RST_V [6] = '{32'h0, 32'h2, 32'h101, 32'h4, 32'h201, 32'h0};
	localparam logic [7:0] REF_A [13] = '{8'h04, 8'h04, 8'h04, 8'h10, 8'h10, 8'h10, 8'h10,
		8'h10, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h0c};
	localparam logic [31:0] REF_W [13] = '{32'h5, 32'h0, 32'h12, 32'h204, 32'h3, 32'h1205,
		32'h1108, 32'h305, 32'h1008, 32'h1109, 32'h0, 32'h270f003f, 32'h27100000};
	localparam logic [31:0] REF_X [13] = '{32'h5, 32'h5, 32'h5, 32'h204, 32'h204, 32'h204,
		32'h1108, 32'h308, 32'h1008, 32'h1008, 32'h1008, 32'h270f003f, 32'h270f003f};
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic mclk_in, bclk, aux_in, amclk, fsref, pin, pin_oe;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata, rd_val;
	int num_errors = 0;
	int compares = 0;
	logic [15:0] fs_seen = 16'h0000;

	acg_src_model u_acg_src_model (.i_mclk(i_mclk), .o_mclk_in(mclk_in), .o_bclk(bclk),
		.o_aux(aux_in));
	acg_top u_acg_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mclk_in(mclk_in), .i_bclk(bclk),
		.i_aux_clock_input_pin(aux_in), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_amclk_tick(amclk), .o_fsref_tick(fsref),
		.o_aux_clock_output_pin(pin), .o_aux_clock_output_pin_oe(pin_oe));

	initial
		forever #12.5 i_mclk = ~i_mclk;

	// Sample rate ticks seen so far, taken where the pulse has settled
	always @(negedge i_mclk)
	begin
		if (fsref)
			fs_seen <= fs_seen + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("compares=%0d mismatches=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// Optional write, then a read of the same place; read data land in rd_val
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= w;
		i_rd <= ~w;
		if (w)
		begin
			@(posedge i_mclk);
			i_wr <= 1'b0;
			i_rd <= 1'b1;
		end
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask : acc

	// Counts source events and output ticks or pin toggles over a window
	task automatic meas(input int src, input logic use_pin, input longint num, input longint den);
		int ev, tk, fs;
		logic [2:0] sp, sv;
		logic po;
		longint ex;
		ev = 0;
		tk = 0;
		fs = 0;
		repeat (40) @(posedge i_mclk);
		#1;
		sp = {aux_in, bclk, mclk_in};
		po = pin;
		repeat (2000)
		begin
			@(posedge i_mclk);
			#1;
			sv = {aux_in, bclk, mclk_in};
			ev += int'(sv[src] != sp[src]);
			tk += use_pin ? int'(pin != po) : int'(amclk);
			fs += int'(fsref);
			sp = sv;
			po = pin;
		end
		ex = longint'(ev) * num / den;
		check({31'h0, longint'(tk) >= ex - 2 && longint'(tk) <= ex + 2}, 32'h1);
		if (use_pin)
			check(pin_oe, 1'b1);
		else
			check({31'h0, fs >= ex / 256 - 1 && fs <= ex / 256 + 1}, 32'h1);
		$display("rate case src=%0d pin=%0d seen=%0d exp=%0d", src, use_pin, tk, ex);
	endtask : meas

	initial
	begin
		repeat (60000) @(posedge i_mclk);
		num_errors++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int q, m, n, p, r, j, d;
		longint k;
		void'($urandom(66366));
		repeat (4) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		foreach (RST_A[i])
		begin
			acc(1'b0, RST_A[i], 32'h0);
			check(rd_val, RST_V[i]);
		end
		foreach (REF_A[i])
		begin
			acc(1'b1, REF_A[i], REF_W[i]);
			check(rd_val, REF_X[i]);
		end
		$display("register cases done");
		for (int s = 0; s < 4; s++)
		begin
			q = (s == 0) ? 2 : (s == 2) ? 17 : 2 * (2 + $urandom % 7);
			acc(1'b1, ACG_OFS_DIVQ, 32'(q));
			acc(1'b1, ACG_OFS_CTRL, 32'(s << 6));
			meas(s % 3, 1'b0, (s < 3) ? 1 : 0, q);
		end
		for (int s = 0; s < 2; s++)
		begin
			j = s ? 55 : 4 + $urandom % 8;
			d = s ? 0 : $urandom % 10000;
			r = s ? 2 : 1;
			p = s ? 8 : 1 + $urandom % 8;
			m = 2 << ($urandom % 3);
			n = 12 + $urandom % 6;
			k = j * 10000 + d;
			acc(1'b1, ACG_OFS_PLLPR, 32'(r << 8 | p));
			acc(1'b1, ACG_OFS_PLLK, 32'(d << 16 | j));
			acc(1'b1, ACG_OFS_OUTDIV, 32'(n << 8 | m));
			acc(1'b1, ACG_OFS_CTRL, 32'(s << 4 | 5));
			meas(s, 1'b0, k * r, 160000 * p);
			meas(s, 1'b1, 2 * k * r, m * n * p * 10000);
			acc(1'b1, ACG_OFS_CTRL, 32'(s << 4 | 1));
			meas(s, 1'b1, 2 * k * r, m * n * p * 10000);
			meas(0, 1'b0, 1, q);
		end
		for (int i = 0; i < 4; i++)
		begin
			m = 1 << i;
			n = (i == 0) ? 2 : 2 + $urandom % 16;
			acc(1'b1, ACG_OFS_OUTDIV, 32'(n << 8 | m));
			acc(1'b1, ACG_OFS_CTRL, 32'(2 | i % 2));
			meas(0, 1'b1, 2, m * n);
		end
		acc(1'b1, ACG_OFS_CTRL, 32'h25);
		meas(0, 1'b0, 0, 1);
		acc(1'b0, ACG_OFS_STATUS, 32'h0);
		check(rd_val[18:17], 2'b11);
		check(rd_val[15:0], fs_seen);
		acc(1'b1, ACG_OFS_CTRL, 32'h0);
		repeat (8) @(posedge i_mclk);
		#1;
		check(pin_oe, 1'b0);
		check(pin, 1'b0);
		acc(1'b0, ACG_OFS_STATUS, 32'h0);
		check(rd_val, {16'h0000, fs_seen});
		$display("aux stop case done");
		end_of_test();
	end

endmodule : testbench
